// *** inc/state_trigger_control_defines.svh ***
// Constants for the state trigger control block.
// Assumes inclusion by the package and by the design module.
`ifndef STATE_TRIGGER_CONTROL_DEFINES_SVH
`define STATE_TRIGGER_CONTROL_DEFINES_SVH

`define STC_PORT_W 8
`define STC_CHAIN_W 48
`define STC_LEVEL_W 4
`define STC_LEVEL_LAST 4'hf
`define STC_LEVEL_FIRST 4'h0
`define STC_LEVEL_STEP 4'h1
`define STC_ST_BOARD_LO 3
`define STC_ADDR_W 3
`define STC_OUT_CTRL 3'h0
`define STC_OUT_PROBE 3'h1
`define STC_IN_STATUS 3'h0
`define STC_IN_ADDR 3'h1
`define STC_RESET_BYTE 8'h00
`define STC_RESET_CHAIN 48'h000000000000
`define STC_CTRL_SER_DATA 0
`define STC_CTRL_SER_SHIFT 1
`define STC_CTRL_RD_ALL_N 2
`define STC_CTRL_RELOAD 3
`define STC_ST_CHAIN_LAST 0
`define STC_ST_EMPTY_N 1
`define STC_ST_POST_EN 2
`define STC_CH_PRESET_LO 0
`define STC_CH_A_FALL 4
`define STC_CH_B_FROM_A 5
`define STC_CH_B_FALL 6
`define STC_CH_Q1_LO 8
`define STC_CH_Q1_CARE 14
`define STC_CH_Q2_LO 20
`define STC_CH_Q2_CARE 26
`define STC_QUAL_W 6

`endif

// *** inc/state_trigger_control_pkg.sv ***
// Types for the state trigger control block.
// Assumes the defines header is on the include path.
`include "state_trigger_control_defines.svh"
package state_trigger_control_pkg;
  typedef struct packed {
    logic [`STC_QUAL_W-1:0] value;
    logic [`STC_QUAL_W-1:0] care;
  } qual_word_t;
  typedef struct packed {
    logic a_fall;
    logic b_from_a;
    logic b_fall;
  } clock_select_t;
  typedef struct packed {
    logic a_first;
    logic b_first;
    logic c_first;
    logic a_second;
    logic b_second;
    logic c_second;
  } qual_match_t;
endpackage

// *** logic/state_trigger_control.sv ***
// State trigger control: port logic, config chain, level stack, clocks.
// Assumes a processor I/O strobe interface synchronous to i_mclk and
// probe clocks/qualifiers arriving asynchronously on pins.
//
// Operation
// - Ports written only on I/O write, read only on I/O read.
// - Read-all-memory strobe, active low, goes to collection counter.
// - Two 8-bit output ports: control port and probe/memory port.
// - Two 8-bit status ports: board status and collection address.
// - Serial data from output bit shifts a 48-bit chain of settings.
// - Chain's last bit is readable in the status port.
// - 4-bit pointer gives next level address to delay memory, latches.
// - Pointer preset from chain and counts only upward to fifteen.
// - Pointer terminal count drives stack-empty low.
// - Pointer output registered for stable trigger memory address.
// - Stack control decides advance or reload of pointer.
// - Active-low level-advance enable steps trigger stacks.
// - Delay-stack advance clock derived from level-advance enable.
// - Post-trigger enable derived from stack-empty starts counting.
// - A latch clock from rising or falling A probe clock.
// - B latch clock from A probe clock or either B edge.
// - Clock select bits come from chain outputs.
// - Qualified low when all first or all second word matches true.
// - Per-probe match high when its two bits equal selected word.
// - Bit order A1,A2,B1,B2,C1,C2; unspecified positions ignored.
// - Read-all-memory low makes collection counter pass inputs.
// - Restart reloads pointer with level 0 address from chain.
`include "state_trigger_control_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module state_trigger_control
  import state_trigger_control_pkg::*;
#(
  parameter int PORT_W = `STC_PORT_W,
  parameter int CHAIN_W = `STC_CHAIN_W
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // Processor I/O port
  input wire logic [`STC_ADDR_W-1:0] i_io_addr,
  input wire logic [PORT_W-1:0] i_io_wdata,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  output logic [PORT_W-1:0] o_io_rdata,
  // Board status and collection address
  input wire logic [PORT_W-1:0] i_board_status,
  input wire logic [PORT_W-1:0] i_collect_addr,
  // Probe and memory board control
  output logic [PORT_W-1:0] o_probe_ctrl,
  output logic o_read_all_memory_n,
  // Stack management
  input wire logic i_restart,
  input wire logic i_level_match,
  output logic [`STC_LEVEL_W-1:0] o_next_level_pointer,
  output logic [`STC_LEVEL_W-1:0] o_level_addr_latched,
  output logic o_level_stack_empty_n,
  output logic o_level_advance_en_n,
  output logic o_delay_stack_advance_clk,
  output logic o_post_trigger_count_en,
  // Probe clocks and qualifiers (pins)
  input wire logic i_a_probe_clock,
  input wire logic i_b_probe_clock,
  input wire logic [`STC_QUAL_W-1:0] i_qual_bits,
  output logic o_a_board_latch_clock,
  output logic o_b_board_latch_clock,
  output logic o_clock_qualified_n,
  output logic [`STC_CHAIN_W-1:0] o_config_chain
);

  // Field positions in the chain are fixed, so other widths cannot work.
  if (PORT_W != `STC_PORT_W || CHAIN_W != `STC_CHAIN_W) begin : g_width_check
    $error("Port and chain widths are fixed by the field map.");
  end

  logic [PORT_W-1:0] ctrl_port_r;
  logic [PORT_W-1:0] probe_port_r;
  logic [CHAIN_W-1:0] chain_r;
  logic shift_d_r;
  logic [`STC_LEVEL_W-1:0] ptr_r;
  logic [`STC_LEVEL_W-1:0] ptr_nxt;
  logic [`STC_LEVEL_W-1:0] ptr_lat_r;
  logic adv_clk_r;
  logic post_en_r;
  logic a_clk_s1_r;
  logic a_clk_s2_r;
  logic a_clk_d_r;
  logic b_clk_s1_r;
  logic b_clk_s2_r;
  logic b_clk_d_r;
  logic [`STC_QUAL_W-1:0] qual_s1_r;
  logic [`STC_QUAL_W-1:0] qual_s2_r;
  logic qual_n_r;
  logic match_s1_r;
  logic match_s2_r;
  logic restart_s1_r;
  logic restart_s2_r;
  logic stack_empty;
  logic advance;
  logic reload;
  logic shift_edge;
  clock_select_t clk_sel;
  qual_word_t q1_word;
  qual_word_t q2_word;
  qual_match_t match;

  // Output ports are only touched by an I/O write.
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl_port_r <= `STC_RESET_BYTE;
      probe_port_r <= `STC_RESET_BYTE;
    end else if (i_io_wr) begin
      if (i_io_addr == `STC_OUT_CTRL) begin
        ctrl_port_r <= i_io_wdata;
      end
      if (i_io_addr == `STC_OUT_PROBE) begin
        probe_port_r <= i_io_wdata;
      end
    end
  end

  // Read data is held in a flop so the bus sees a stable byte.
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_io_rdata <= `STC_RESET_BYTE;
    end else if (i_io_rd) begin
      unique case (i_io_addr)
        `STC_IN_STATUS: begin
          o_io_rdata <= {i_board_status[PORT_W-1:`STC_ST_BOARD_LO], post_en_r,
                         stack_empty ? 1'b0 : 1'b1,
                         chain_r[CHAIN_W-1]};
        end
        `STC_IN_ADDR: begin
          o_io_rdata <= i_collect_addr;
        end
        // Unused addresses read as zero so a stray read is harmless.
        default: begin
          o_io_rdata <= `STC_RESET_BYTE;
        end
      endcase
    end
  end

  assign o_probe_ctrl = probe_port_r;
  assign o_read_all_memory_n = ctrl_port_r[`STC_CTRL_RD_ALL_N];

  // The chain shifts on the rising edge of the software shift bit, so
  // one data bit enters per pair of port writes.
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      shift_d_r <= 1'b0;
    end else begin
      shift_d_r <= ctrl_port_r[`STC_CTRL_SER_SHIFT];
    end
  end
  assign shift_edge = ctrl_port_r[`STC_CTRL_SER_SHIFT] & ~shift_d_r;

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      chain_r <= `STC_RESET_CHAIN;
    end else if (shift_edge) begin
      chain_r <= {chain_r[CHAIN_W-2:0],
                  ctrl_port_r[`STC_CTRL_SER_DATA]};
    end
  end
  assign o_config_chain = chain_r;

  assign clk_sel.a_fall = chain_r[`STC_CH_A_FALL];
  assign clk_sel.b_from_a = chain_r[`STC_CH_B_FROM_A];
  assign clk_sel.b_fall = chain_r[`STC_CH_B_FALL];
  assign q1_word.value = chain_r[`STC_CH_Q1_LO +: `STC_QUAL_W];
  assign q1_word.care = chain_r[`STC_CH_Q1_CARE +: `STC_QUAL_W];
  assign q2_word.value = chain_r[`STC_CH_Q2_LO +: `STC_QUAL_W];
  assign q2_word.care = chain_r[`STC_CH_Q2_CARE +: `STC_QUAL_W];

  // Pin inputs pass two flops before use; the probe clocks are sampled
  // like data, so their high and low phases must span several clocks.
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      a_clk_s1_r <= 1'b0;
      a_clk_s2_r <= 1'b0;
      b_clk_s1_r <= 1'b0;
      b_clk_s2_r <= 1'b0;
    end else begin
      a_clk_s1_r <= i_a_probe_clock;
      a_clk_s2_r <= a_clk_s1_r;
      b_clk_s1_r <= i_b_probe_clock;
      b_clk_s2_r <= b_clk_s1_r;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      qual_s1_r <= 6'h00;
      qual_s2_r <= 6'h00;
    end else begin
      qual_s1_r <= i_qual_bits;
      qual_s2_r <= qual_s1_r;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      match_s1_r <= 1'b0;
      match_s2_r <= 1'b0;
      restart_s1_r <= 1'b0;
      restart_s2_r <= 1'b0;
    end else begin
      match_s1_r <= i_level_match;
      match_s2_r <= match_s1_r;
      restart_s1_r <= i_restart;
      restart_s2_r <= restart_s1_r;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      a_clk_d_r <= 1'b0;
      b_clk_d_r <= 1'b0;
    end else begin
      a_clk_d_r <= a_clk_s2_r;
      b_clk_d_r <= b_clk_s2_r;
    end
  end

  // Latch clocks are one-cycle pulses on the selected probe edge; the
  // oversampled form limits probe rates to well below the system clock.
  logic a_rise;
  logic a_fall;
  logic b_rise;
  logic b_fall;
  logic a_latch;
  assign a_rise = a_clk_s2_r & ~a_clk_d_r;
  assign a_fall = ~a_clk_s2_r & a_clk_d_r;
  assign b_rise = b_clk_s2_r & ~b_clk_d_r;
  assign b_fall = ~b_clk_s2_r & b_clk_d_r;
  assign a_latch = clk_sel.a_fall ? a_fall : a_rise;

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_a_board_latch_clock <= 1'b0;
    end else begin
      o_a_board_latch_clock <= a_latch;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_b_board_latch_clock <= 1'b0;
    end else begin
      o_b_board_latch_clock <= clk_sel.b_from_a ? a_latch :
                               (clk_sel.b_fall ? b_fall : b_rise);
    end
  end

  // Per-probe match: both bits of a probe must agree where cared for.
  genvar gp;
  logic [2:0] m1;
  logic [2:0] m2;
  generate
    for (gp = 0; gp < 3; gp++) begin : g_probe
      localparam int HI = `STC_QUAL_W - 1 - 2 * gp;
      assign m1[gp] = &(~((qual_s2_r[HI-:2] ^ q1_word.value[HI-:2]) &
                          q1_word.care[HI-:2]));
      assign m2[gp] = &(~((qual_s2_r[HI-:2] ^ q2_word.value[HI-:2]) &
                          q2_word.care[HI-:2]));
    end
  endgenerate
  assign match = '{a_first: m1[0], b_first: m1[1], c_first: m1[2],
                   a_second: m2[0], b_second: m2[1], c_second: m2[2]};

  // The compare is registered so skew between qualifier pins cannot glitch.
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      qual_n_r <= 1'b1;
    end else begin
      qual_n_r <= ~((match.a_first & match.b_first & match.c_first) |
                    (match.a_second & match.b_second &
                     match.c_second));
    end
  end
  assign o_clock_qualified_n = qual_n_r;

  // Stack control: advance on a qualified latch edge with a level match.
  // Reload wins over advance, and the enable stays off while reloading.
  assign stack_empty = (ptr_r == `STC_LEVEL_LAST);
  assign reload = restart_s2_r | ctrl_port_r[`STC_CTRL_RELOAD];
  assign advance = match_s2_r & ~qual_n_r & a_latch & ~stack_empty &
                   ~reload;

  always_comb begin
    ptr_nxt = ptr_r;
    if (reload) begin
      ptr_nxt = chain_r[`STC_CH_PRESET_LO +: `STC_LEVEL_W];
    end else if (advance) begin
      ptr_nxt = ptr_r + `STC_LEVEL_STEP;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ptr_r <= `STC_LEVEL_FIRST;
    end else begin
      ptr_r <= ptr_nxt;
    end
  end
  assign o_next_level_pointer = ptr_r;

  // The latched copy trails the pointer by one clock, so it is settled.
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ptr_lat_r <= `STC_LEVEL_FIRST;
    end else begin
      ptr_lat_r <= ptr_r;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      adv_clk_r <= 1'b0;
    end else begin
      adv_clk_r <= advance;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      post_en_r <= 1'b0;
    end else begin
      post_en_r <= stack_empty;
    end
  end

  assign o_level_addr_latched = ptr_lat_r;
  assign o_level_stack_empty_n = ~stack_empty;
  assign o_level_advance_en_n = ~advance;
  assign o_delay_stack_advance_clk = adv_clk_r;
  assign o_post_trigger_count_en = post_en_r;

endmodule

`default_nettype wire

// *** tb/io_host_model.sv ***
// Host processor model issuing I/O writes and reads to the block.
// Assumes the bench calls its tasks; strobes change after falling edges.
`timescale 1ns/100ps
`default_nettype none
module io_host_model (
  // Clock
  input wire logic i_mclk,
  // I/O strobes
  output logic [2:0] o_io_addr,
  output logic [7:0] o_io_wdata,
  output logic o_io_wr,
  output logic o_io_rd,
  input wire logic [7:0] i_io_rdata
);
  initial begin
    o_io_addr = 3'h7;
    o_io_wdata = 8'h00;
    o_io_wr = 1'b0;
    o_io_rd = 1'b0;
  end
  // Idle lines show the inverse of the last value, never a stale copy.
  task automatic put(input logic [2:0] a, input logic [7:0] d,
                     input logic w);
    @(negedge i_mclk);
    o_io_addr = a;
    o_io_wdata = d;
    o_io_wr = w;
    o_io_rd = !w;
    @(negedge i_mclk);
    o_io_addr = ~a;
    o_io_wdata = ~d;
    o_io_wr = 1'b0;
    o_io_rd = 1'b0;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    put(a, d, 1'b1);
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    put(a, 8'h00, 1'b0);
    d = i_io_rdata;
  endtask
endmodule
`default_nettype wire

// *** tb/state_trigger_control_checker.sv ***
// Assertions on the state trigger control ports, bound into the design module.
// Assumes the design's defines header and package are compiled first.
`include "state_trigger_control_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module state_trigger_control_checker
  import state_trigger_control_pkg::*;
#(
  parameter int PORT_W = `STC_PORT_W,
  parameter int CHAIN_W = `STC_CHAIN_W
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // Processor port
  input wire logic [`STC_ADDR_W-1:0] i_io_addr,
  input wire logic [PORT_W-1:0] i_io_wdata,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic [PORT_W-1:0] o_io_rdata,
  input wire logic [PORT_W-1:0] i_collect_addr,
  input wire logic [PORT_W-1:0] o_probe_ctrl,
  // Level stack
  input wire logic [`STC_LEVEL_W-1:0] o_next_level_pointer,
  input wire logic [`STC_LEVEL_W-1:0] o_level_addr_latched,
  input wire logic o_level_stack_empty_n,
  input wire logic o_level_advance_en_n,
  input wire logic o_delay_stack_advance_clk,
  input wire logic o_post_trigger_count_en
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_b);
  a_probe_port_write: assert property (
    i_io_wr && i_io_addr == `STC_OUT_PROBE |=> o_probe_ctrl == $past(i_io_wdata))
    else $error("probe port write lost");
  a_addr_port_read: assert property (
    i_io_rd && i_io_addr == `STC_IN_ADDR |=> o_io_rdata == $past(i_collect_addr))
    else $error("address port read wrong");
  a_unmapped_read_zero: assert property (
    i_io_rd && i_io_addr >= 3'h2 |=> o_io_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_empty_at_last: assert property (
    o_level_stack_empty_n == (o_next_level_pointer != `STC_LEVEL_LAST))
    else $error("stack empty mismatch");
  a_latched_level: assert property (
    o_level_addr_latched == $past(o_next_level_pointer))
    else $error("latched level wrong");
  a_post_from_empty: assert property (
    o_post_trigger_count_en == !$past(o_level_stack_empty_n))
    else $error("post trigger enable wrong");
  a_pointer_step_one: assert property (
    !o_level_advance_en_n |=> o_next_level_pointer ==
      $past(o_next_level_pointer) + 4'h1)
    else $error("pointer step not one");
  a_no_step_at_end: assert property (
    !o_level_advance_en_n |-> o_level_stack_empty_n)
    else $error("advance at terminal level");
  a_delay_clk_follow: assert property (
    o_delay_stack_advance_clk == !$past(o_level_advance_en_n))
    else $error("delay stack clock wrong");
endmodule
bind state_trigger_control state_trigger_control_checker #(
  .PORT_W(PORT_W),
  .CHAIN_W(CHAIN_W)
) chk_u (
  .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_io_addr(i_io_addr),
  .i_io_wdata(i_io_wdata), .i_io_wr(i_io_wr), .i_io_rd(i_io_rd),
  .o_io_rdata(o_io_rdata), .i_collect_addr(i_collect_addr),
  .o_probe_ctrl(o_probe_ctrl), .o_next_level_pointer(o_next_level_pointer),
  .o_level_addr_latched(o_level_addr_latched),
  .o_level_stack_empty_n(o_level_stack_empty_n),
  .o_level_advance_en_n(o_level_advance_en_n),
  .o_delay_stack_advance_clk(o_delay_stack_advance_clk),
  .o_post_trigger_count_en(o_post_trigger_count_en)
);
`default_nettype wire

// *** tb/state_trigger_control_tb.sv ***
// Bench for the state trigger control block: ports, chain, stack, clocks.
// Assumes the host model drives the I/O strobes after falling edges.
`timescale 1ns/100ps
`default_nettype none
module state_trigger_control_tb;
  logic i_mclk = 1'b0;
  logic i_rst_b = 1'b0;
  logic [2:0] io_addr;
  logic [7:0] io_wdata, io_rdata, rd_v, probe, status, caddr;
  logic io_wr, io_rd, rst_lvl, match, a_clk, b_clk, rd_all_n;
  logic empty_n, post_en, a_lc, b_lc, qual_n;
  logic [5:0] qual;
  logic [3:0] ptr;
  logic [47:0] chain;
  // Preset 15 minus 2 leaves three levels; word one cares for bit A1 only.
  logic [47:0] cfg = {16'ha5c3, 6'h3f, 6'h3f, 6'h20, 6'h20, 8'h0d};
  logic [6:0] qv [5] = '{7'h40, 7'h21, 7'h7e, 7'h3f, 7'h01};
  int failures = 0;
  int tests_run = 0;
  int a_cnt = 0;
  int b_cnt = 0;
  always #12.5 i_mclk = ~i_mclk;
  io_host_model host_u (.i_mclk(i_mclk), .o_io_addr(io_addr),
    .o_io_wdata(io_wdata), .o_io_wr(io_wr), .o_io_rd(io_rd),
    .i_io_rdata(io_rdata));
  state_trigger_control dut_u (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
    .i_io_addr(io_addr), .i_io_wdata(io_wdata), .i_io_wr(io_wr),
    .i_io_rd(io_rd), .o_io_rdata(io_rdata), .i_board_status(status),
    .i_collect_addr(caddr), .o_probe_ctrl(probe),
    .o_read_all_memory_n(rd_all_n), .i_restart(rst_lvl),
    .i_level_match(match), .o_next_level_pointer(ptr),
    .o_level_addr_latched(), .o_level_stack_empty_n(empty_n),
    .o_level_advance_en_n(), .o_delay_stack_advance_clk(),
    .o_post_trigger_count_en(post_en), .i_a_probe_clock(a_clk),
    .i_b_probe_clock(b_clk), .i_qual_bits(qual),
    .o_a_board_latch_clock(a_lc), .o_b_board_latch_clock(b_lc),
    .o_clock_qualified_n(qual_n), .o_config_chain(chain));
  always @(negedge i_mclk) begin
    a_cnt += (a_lc === 1'b1);
    b_cnt += (b_lc === 1'b1);
  end
  task automatic check(input string nm, input logic [47:0] got,
                       input logic [47:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge i_mclk);
  endtask
  // Probe clocks are slow beside the 3-cycle path from pin to latch clock.
  task automatic pulse(input logic [1:0] s);
    {b_clk, a_clk} = s;
    cyc(6);
    {b_clk, a_clk} = 2'b00;
    cyc(6);
  endtask
  // The last shift lands one clock after its port write, hence the wait.
  task automatic shove(input logic [47:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      host_u.wr(3'h0, {6'h01, 1'b0, v[i]});
      host_u.wr(3'h0, {6'h01, 1'b1, v[i]});
    end
    cyc(1);
  endtask
  initial begin
    {rst_lvl, match, a_clk, b_clk} = 4'h0;
    qual = 6'h00;
    status = 8'ha8;
    caddr = 8'h3c;
    repeat (6) @(posedge i_mclk);
    @(negedge i_mclk);
    i_rst_b = 1'b1;
    check("probe reset", 48'(probe), 48'h0);
    check("chain reset", chain, 48'h0);
    host_u.wr(3'h1, 8'h5a);
    check("probe port", 48'(probe), 48'h5a);
    host_u.wr(3'h5, 8'h00);
    host_u.rd(3'h5, rd_v);
    check("unmapped", 48'({probe, rd_v}), 48'h5a00);
    host_u.rd(3'h1, rd_v);
    check("address port", 48'(rd_v), 48'h3c);
    host_u.rd(3'h0, rd_v);
    check("status port", 48'(rd_v), 48'haa);
    host_u.wr(3'h0, 8'h04);
    check("read all", 48'(rd_all_n), 48'h1);
    shove(cfg, 48);
    check("chain", chain, cfg);
    host_u.rd(3'h0, rd_v);
    check("chain end", 48'(rd_v[0]), 48'(cfg[47]));
    host_u.wr(3'h0, 8'h0c);
    host_u.wr(3'h0, 8'h04);
    check("preset", 48'({ptr, empty_n}), 48'h1b);
    foreach (qv[k]) begin
      qual = qv[k][6:1];
      cyc(5);
      check("qualified", 48'(qual_n), 48'(qv[k][0]));
    end
    qual = 6'h20;
    match = 1'b1;
    cyc(4);
    repeat (3) pulse(2'b01);
    check("a latch", 48'(a_cnt), 48'h3);
    check("top hold", 48'({ptr, empty_n}), 48'h1e);
    host_u.rd(3'h0, rd_v);
    check("empty status", 48'({rd_v, post_en}), 48'h15b);
    repeat (2) pulse(2'b10);
    check("b latch", 48'(b_cnt), 48'h2);
    match = 1'b0;
    rst_lvl = 1'b1;
    cyc(4);
    rst_lvl = 1'b0;
    cyc(2);
    check("restart", 48'({ptr, empty_n}), 48'h1b);
    shove(48'h5d, 8);
    pulse(2'b11);
    check("falling edges", 48'({a_cnt[3:0], b_cnt[3:0]}), 48'h43);
    shove(48'h3d, 8);
    pulse(2'b10);
    pulse(2'b01);
    check("b from a", 48'({a_cnt[3:0], b_cnt[3:0]}), 48'h54);
    check("chain moved", chain, {cfg[31:0], 16'h5d3d});
    tally_and_finish();
  end
  // The tests need under a thousand cycles; five thousand means a hang.
  initial begin
    repeat (5000) @(posedge i_mclk);
    failures++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
